// file: design/smm_top.sv
// two software-selected status monitor multiplexers with register port and interrupt
`timescale 1ns/1ps
// Operation
// RQ1: monitor zero takes its source from the six low bits of its select register, the top two bits read zero.
// RQ2: monitor one has its own six-bit select register and decodes the same source codes.
// RQ3: code 0 drives low, code 1 both locks, code 2 first pll lock, code 3 second pll lock.
// RQ4: code 4 shows both references missing, code 5 that plus the second pll locked.
// RQ5: code 6 shows that the second reference is chosen, meaningful only under automatic choice.
// RQ6: codes 7 to 12 show first, second and test reference, oscillator, first pll feedback, second pll ref health.
// RQ7: code 13 is reserved and drives low, code 14 shows both references healthy.
// RQ8: code 15 shows every monitored clock healthy, leaving the test reference out.
// RQ9: codes 16 to 19 show half-rate feedback, down pulse, reference and up pulse of the first pll.
// RQ10: software keeps to codes up to 23, codes 20 to 23 and all above drive low.
module smm_top (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [smm_pkg::ADDR_W-1:0] ADDR,
	input wire logic [smm_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [smm_pkg::DATA_W-1:0] RDATA,
	input wire smm_pkg::smm_status_t STATUS,
	input wire smm_pkg::smm_pll1_t PLL1_RAW,
	output logic MON0,
	output logic MON1,
	output logic IRQ
);
	logic [smm_pkg::STS_W-1:0] sts_vec;
	logic [smm_pkg::PLL1_W-1:0] half_vec;
	smm_pkg::smm_status_t sts_s;
	smm_pkg::smm_pll1_t half_s;
	logic [smm_pkg::SEL_W-1:0] sel0_r;
	logic [smm_pkg::SEL_W-1:0] sel1_r;
	logic [smm_pkg::IRQ_W-1:0] mask_r;
	logic [smm_pkg::IRQ_W-1:0] irq_stat_r;
	logic [smm_pkg::IRQ_W-1:0] irq_stat_nxt;
	logic [smm_pkg::IRQ_W-1:0] irq_ev;
	logic [smm_pkg::IRQ_W-1:0] irq_clr;
	logic mon0_nxt;
	logic mon1_nxt;
	logic mon0_d_r;
	logic mon1_d_r;
	logic lock_d_r;
	logic hold_d_r;
	logic wr_sel0;
	logic wr_sel1;

	// status conditions arrive from other clock domains
	smm_sync #(
		.W(smm_pkg::STS_W)
	) smm_sync_i (
		.clk(MCLK),
		.rst_n(RST_N),
		.d(STATUS),
		.q(sts_vec)
	);

	// first-pll signals synchronised and halved
	smm_div2 #(
		.W(smm_pkg::PLL1_W)
	) smm_div2_i (
		.clk(MCLK),
		.rst_n(RST_N),
		.d(PLL1_RAW),
		.q(half_vec)
	);

	assign sts_s = smm_pkg::smm_status_t'(sts_vec);
	assign half_s = smm_pkg::smm_pll1_t'(half_vec);

	// source decode shared by both monitors
	function automatic logic smm_pick(
		input logic [smm_pkg::SEL_W-1:0] sel,
		input smm_pkg::smm_status_t s,
		input smm_pkg::smm_pll1_t h
	);
		logic o;
		o = 1'b0;
		case (sel)
			smm_pkg::SEL_GND: o = 1'b0; // RQ3
			smm_pkg::SEL_BOTH_LOCK: o = s.pll1_lock & s.pll2_lock; // RQ3
			smm_pkg::SEL_PLL1_LOCK: o = s.pll1_lock; // RQ3
			smm_pkg::SEL_PLL2_LOCK: o = s.pll2_lock; // RQ3
			smm_pkg::SEL_BOTH_MISSING: o = s.both_missing; // RQ4
			smm_pkg::SEL_MISSING_LOCK: o = s.both_missing & s.pll2_lock; // RQ4
			smm_pkg::SEL_SECOND_SEL: o = s.second_selected; // RQ5
			smm_pkg::SEL_FIRST_OK: o = s.first_ok; // RQ6
			smm_pkg::SEL_SECOND_OK: o = s.second_ok; // RQ6
			smm_pkg::SEL_TEST_OK: o = s.test_ok; // RQ6
			smm_pkg::SEL_XO_OK: o = s.xo_ok; // RQ6
			smm_pkg::SEL_FB_OK: o = s.pll1_fb_ok; // RQ6
			smm_pkg::SEL_PLL2_REF_OK: o = s.pll2_ref_ok; // RQ6
			smm_pkg::SEL_RESERVED: o = 1'b0; // RQ7
			smm_pkg::SEL_REFS_OK: o = s.first_ok & s.second_ok; // RQ7
			smm_pkg::SEL_ALL_OK: begin
				// test reference deliberately left out
				o = s.first_ok & s.second_ok & s.xo_ok & s.pll1_fb_ok & s.pll2_ref_ok & s.pll2_fb_ok; // RQ8
			end
			smm_pkg::SEL_HALF_FB: o = h.fb_clk; // RQ9
			smm_pkg::SEL_HALF_DN: o = h.pfd_dn; // RQ9
			smm_pkg::SEL_HALF_REF: o = h.ref_clk; // RQ9
			smm_pkg::SEL_HALF_UP: o = h.pfd_up; // RQ9
			default: o = 1'b0; // RQ10
		endcase
		return o;
	endfunction

	// write decode for the select registers
	assign wr_sel0 = WR && (ADDR == smm_pkg::OFS_MON0_SEL);
	assign wr_sel1 = WR && (ADDR == smm_pkg::OFS_MON1_SEL);

	// monitor zero select, reserved upper bits dropped
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sel0_r <= smm_pkg::RST_SEL;
		end else if (wr_sel0) begin
			sel0_r <= WDATA[smm_pkg::SEL_MSB:smm_pkg::SEL_LSB]; // RQ1
		end
	end

	// monitor one select
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sel1_r <= smm_pkg::RST_SEL;
		end else if (wr_sel1) begin
			sel1_r <= WDATA[smm_pkg::SEL_MSB:smm_pkg::SEL_LSB]; // RQ2
		end
	end

	// interrupt mask
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_r <= smm_pkg::RST_MASK;
		end else if (WR && (ADDR == smm_pkg::OFS_IRQ_MASK)) begin
			mask_r <= WDATA[smm_pkg::IRQ_W-1:0];
		end
	end

	// both monitors share one decoder
	assign mon0_nxt = smm_pick(sel0_r, sts_s, half_s); // RQ1
	assign mon1_nxt = smm_pick(sel1_r, sts_s, half_s); // RQ2

	// monitor outputs straight from flops
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			MON0 <= 1'b0;
			MON1 <= 1'b0;
		end else begin
			MON0 <= mon0_nxt;
			MON1 <= mon1_nxt;
		end
	end

	// history for event edges
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			mon0_d_r <= 1'b0;
			mon1_d_r <= 1'b0;
			lock_d_r <= 1'b0;
			hold_d_r <= 1'b0;
		end else begin
			mon0_d_r <= MON0;
			mon1_d_r <= MON1;
			lock_d_r <= sts_s.pll1_lock & sts_s.pll2_lock;
			hold_d_r <= sts_s.both_missing;
		end
	end

	// events: monitor rises, lock lost, holdover entered
	always_comb begin
		irq_ev = '0;
		irq_ev[smm_pkg::IRQ_MON0_RISE] = MON0 & ~mon0_d_r;
		irq_ev[smm_pkg::IRQ_MON1_RISE] = MON1 & ~mon1_d_r;
		irq_ev[smm_pkg::IRQ_LOCK_LOST] = lock_d_r & ~(sts_s.pll1_lock & sts_s.pll2_lock);
		irq_ev[smm_pkg::IRQ_HOLDOVER] = sts_s.both_missing & ~hold_d_r;
	end

	// write one to clear, a new event wins over the clear
	assign irq_clr = (WR && (ADDR == smm_pkg::OFS_IRQ_STAT)) ? WDATA[smm_pkg::IRQ_W-1:0] : '0;
	assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

	// sticky status and level interrupt
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_stat_r <= '0;
			IRQ <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			IRQ <= |(irq_stat_nxt & mask_r);
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= smm_pkg::RST_RDATA;
		end else if (RD) begin
			case (ADDR)
				smm_pkg::OFS_MON0_SEL: RDATA <= {2'h0, sel0_r}; // RQ1
				smm_pkg::OFS_MON1_SEL: RDATA <= {2'h0, sel1_r}; // RQ2
				smm_pkg::OFS_IRQ_STAT: RDATA <= {4'h0, irq_stat_r};
				smm_pkg::OFS_IRQ_MASK: RDATA <= {4'h0, mask_r};
				smm_pkg::OFS_LIVE_CLK: begin
					RDATA <= {sts_s.pll2_fb_ok, sts_s.pll2_ref_ok, sts_s.xo_ok, sts_s.test_ok,
						sts_s.second_ok, sts_s.first_ok, sts_s.pll2_lock, sts_s.pll1_lock};
				end
				smm_pkg::OFS_LIVE_MON: begin
					RDATA <= {3'h0, MON1, MON0, sts_s.pll1_fb_ok, sts_s.both_missing, sts_s.second_selected};
				end
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// checks on the design's own behaviour
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence s_write_sel0;
		WR && (ADDR == smm_pkg::OFS_MON0_SEL);
	endsequence

	sequence s_read_sel0;
		RD && (ADDR == smm_pkg::OFS_MON0_SEL);
	endsequence

	property p_sel0_store;
		s_write_sel0 |=> (sel0_r == $past(WDATA[5:0]));
	endproperty
	a_sel0_store: assert property (p_sel0_store) else $error("monitor zero select not stored"); // RQ1

	property p_sel0_read;
		(s_write_sel0 ##1 s_read_sel0) |=> (RDATA == {2'h0, $past(WDATA[5:0], 2)});
	endproperty
	a_sel0_read: assert property (p_sel0_read) else $error("monitor zero select reads back wrong"); // RQ1

	property p_sel1_same_decode;
		(sel0_r == sel1_r) |=> (MON0 == MON1);
	endproperty
	a_sel1_same_decode: assert property (p_sel1_same_decode) else $error("monitors decode one code differently"); // RQ2

	property p_gnd;
		(sel0_r == 6'h00) |=> !MON0;
	endproperty
	a_gnd: assert property (p_gnd) else $error("code zero does not hold output low"); // RQ3

	property p_both_lock;
		(sel0_r == 6'h01) |=> (MON0 == ($past(sts_s.pll1_lock) & $past(sts_s.pll2_lock)));
	endproperty
	a_both_lock: assert property (p_both_lock) else $error("combined lock output wrong"); // RQ3

	property p_missing_lock;
		(sel1_r == 6'h05) |=> (MON1 == ($past(sts_s.both_missing) & $past(sts_s.pll2_lock)));
	endproperty
	a_missing_lock: assert property (p_missing_lock) else $error("missing with lock output wrong"); // RQ4

	property p_second_sel;
		(sel0_r == 6'h06) |=> (MON0 == $past(sts_s.second_selected));
	endproperty
	a_second_sel: assert property (p_second_sel) else $error("selected reference output wrong"); // RQ5

	property p_xo_ok;
		(sel1_r == 6'h0a) |=> (MON1 == $past(sts_s.xo_ok));
	endproperty
	a_xo_ok: assert property (p_xo_ok) else $error("oscillator health output wrong"); // RQ6

	property p_reserved_low;
		(sel0_r == 6'h0d) [*2] |=> !MON0;
	endproperty
	a_reserved_low: assert property (p_reserved_low) else $error("reserved code drives output high"); // RQ7

	property p_all_ok;
		(sel0_r == 6'h0f) && sts_s.first_ok && sts_s.second_ok && sts_s.xo_ok && sts_s.pll1_fb_ok
			&& sts_s.pll2_ref_ok && sts_s.pll2_fb_ok && !sts_s.test_ok |=> MON0;
	endproperty
	a_all_ok: assert property (p_all_ok) else $error("all clocks ok depends on test reference"); // RQ8

	property p_half_fb;
		(sel0_r == 6'h10) |=> (MON0 == $past(half_s.fb_clk));
	endproperty
	a_half_fb: assert property (p_half_fb) else $error("half rate feedback not routed"); // RQ9

	property p_high_codes_low;
		(sel1_r > 6'h13) |=> !MON1;
	endproperty
	a_high_codes_low: assert property (p_high_codes_low) else $error("unused code drives output high"); // RQ10

	property p_irq_level;
		$stable(mask_r) |-> (IRQ == |(irq_stat_r & mask_r));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level disagrees with status and mask");

	property p_rdata_idle;
		!RD |=> (RDATA == 8'h00);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data present without a read");

	property p_pll1_lock;
		(sel1_r == smm_pkg::SEL_PLL1_LOCK) |=> (MON1 == $past(sts_s.pll1_lock));
	endproperty
	a_pll1_lock: assert property (p_pll1_lock) else $error("first lock output wrong"); // RQ3

	property p_pll2_lock;
		(sel0_r == smm_pkg::SEL_PLL2_LOCK) |=> (MON0 == $past(sts_s.pll2_lock));
	endproperty
	a_pll2_lock: assert property (p_pll2_lock) else $error("second lock output wrong"); // RQ3

	property p_both_missing;
		(sel0_r == smm_pkg::SEL_BOTH_MISSING) |=> (MON0 == $past(sts_s.both_missing));
	endproperty
	a_both_missing: assert property (p_both_missing) else $error("both references missing output wrong"); // RQ4

	property p_first_ok;
		(sel1_r == smm_pkg::SEL_FIRST_OK) |=> (MON1 == $past(sts_s.first_ok));
	endproperty
	a_first_ok: assert property (p_first_ok) else $error("first reference health output wrong"); // RQ6

	property p_test_ok;
		(sel0_r == smm_pkg::SEL_TEST_OK) |=> (MON0 == $past(sts_s.test_ok));
	endproperty
	a_test_ok: assert property (p_test_ok) else $error("test reference health output wrong"); // RQ6

	property p_pll2_ref_ok;
		(sel1_r == smm_pkg::SEL_PLL2_REF_OK) |=> (MON1 == $past(sts_s.pll2_ref_ok));
	endproperty
	a_pll2_ref_ok: assert property (p_pll2_ref_ok) else $error("second pll reference health output wrong"); // RQ6

	property p_refs_ok;
		(sel1_r == smm_pkg::SEL_REFS_OK) |=> (MON1 == ($past(sts_s.first_ok) & $past(sts_s.second_ok)));
	endproperty
	a_refs_ok: assert property (p_refs_ok) else $error("both references healthy output wrong"); // RQ7

	property p_all_ok_drop;
		(sel0_r == smm_pkg::SEL_ALL_OK) && !sts_s.xo_ok |=> !MON0;
	endproperty
	a_all_ok_drop: assert property (p_all_ok_drop) else $error("all clocks ok with oscillator down"); // RQ8

	property p_half_up;
		(sel1_r == smm_pkg::SEL_HALF_UP) |=> (MON1 == $past(half_s.pfd_up));
	endproperty
	a_half_up: assert property (p_half_up) else $error("half rate up pulse not routed"); // RQ9

	property p_mon0_event;
		$rose(MON0) |=> irq_stat_r[smm_pkg::IRQ_MON0_RISE];
	endproperty
	a_mon0_event: assert property (p_mon0_event) else $error("monitor zero rise not recorded");

	property p_irq_sticky;
		(irq_stat_r[smm_pkg::IRQ_MON0_RISE]
			&& !(WR && (ADDR == smm_pkg::OFS_IRQ_STAT) && WDATA[smm_pkg::IRQ_MON0_RISE])) |=> irq_stat_r[0];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("status bit lost without a clear");
endmodule

// file: include/smm_pkg.sv
// package of constants and carrier types for the status monitor multiplexers
package smm_pkg;
	// register port geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int SEL_W = 6;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 5;
	// register offsets
	localparam logic [9:0] OFS_MON0_SEL = 10'h230;
	localparam logic [9:0] OFS_MON1_SEL = 10'h231;
	localparam logic [9:0] OFS_IRQ_STAT = 10'h238;
	localparam logic [9:0] OFS_IRQ_MASK = 10'h239;
	localparam logic [9:0] OFS_LIVE_CLK = 10'h23a;
	localparam logic [9:0] OFS_LIVE_MON = 10'h23b;
	// reset values
	localparam logic [5:0] RST_SEL = 6'h00;
	localparam logic [3:0] RST_MASK = 4'h0;
	localparam logic [7:0] RST_RDATA = 8'h00;
	// select codes of both monitors
	localparam logic [5:0] SEL_GND = 6'h00;
	localparam logic [5:0] SEL_BOTH_LOCK = 6'h01;
	localparam logic [5:0] SEL_PLL1_LOCK = 6'h02;
	localparam logic [5:0] SEL_PLL2_LOCK = 6'h03;
	localparam logic [5:0] SEL_BOTH_MISSING = 6'h04;
	localparam logic [5:0] SEL_MISSING_LOCK = 6'h05;
	localparam logic [5:0] SEL_SECOND_SEL = 6'h06;
	localparam logic [5:0] SEL_FIRST_OK = 6'h07;
	localparam logic [5:0] SEL_SECOND_OK = 6'h08;
	localparam logic [5:0] SEL_TEST_OK = 6'h09;
	localparam logic [5:0] SEL_XO_OK = 6'h0a;
	localparam logic [5:0] SEL_FB_OK = 6'h0b;
	localparam logic [5:0] SEL_PLL2_REF_OK = 6'h0c;
	localparam logic [5:0] SEL_RESERVED = 6'h0d;
	localparam logic [5:0] SEL_REFS_OK = 6'h0e;
	localparam logic [5:0] SEL_ALL_OK = 6'h0f;
	localparam logic [5:0] SEL_HALF_FB = 6'h10;
	localparam logic [5:0] SEL_HALF_DN = 6'h11;
	localparam logic [5:0] SEL_HALF_REF = 6'h12;
	localparam logic [5:0] SEL_HALF_UP = 6'h13;
	localparam logic [5:0] SEL_LAST_GND = 6'h17;
	// interrupt bit positions
	localparam int IRQ_W = 4;
	localparam int IRQ_MON0_RISE = 0;
	localparam int IRQ_MON1_RISE = 1;
	localparam int IRQ_LOCK_LOST = 2;
	localparam int IRQ_HOLDOVER = 3;
	// status conditions from the clocking core
	typedef struct packed {
		logic pll1_lock;
		logic pll2_lock;
		logic both_missing;
		logic second_selected;
		logic first_ok;
		logic second_ok;
		logic test_ok;
		logic xo_ok;
		logic pll1_fb_ok;
		logic pll2_ref_ok;
		logic pll2_fb_ok;
	} smm_status_t;
	// raw first-pll signals
	typedef struct packed {
		logic fb_clk;
		logic pfd_dn;
		logic ref_clk;
		logic pfd_up;
	} smm_pll1_t;
	localparam int STS_W = $bits(smm_status_t);
	localparam int PLL1_W = $bits(smm_pll1_t);
endpackage

// file: design/smm_sync.sv
// two-stage synchroniser for a vector of independent levels
`timescale 1ns/1ps
module smm_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage is read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// file: design/smm_div2.sv
// synchronised divide-by-two of several pin signals
`timescale 1ns/1ps
module smm_div2 #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] prev_r;
	logic [W-1:0] rise;

	// two flops before any logic looks at the pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign rise = sync_r & ~prev_r;

	// toggle on each rising edge, halving the rate
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= q ^ rise; // RQ9
		end
	end

	property p_div_toggle;
		@(posedge clk) disable iff (!rst_n)
		(q != $past(q)) |-> ($past(rise) == ($past(q) ^ q));
	endproperty
	a_div_toggle: assert property (p_div_toggle) else $error("half rate output moved without a rising edge"); // RQ9
endmodule

// file: bench/smm_observer.sv
// partner model: observer that counts rising edges of a status monitor pin
`timescale 1ns/1ps
module smm_observer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mon,
	output logic [15:0] rises
);
	logic last_r;
	// count each low-to-high step of the watched pin, half-rate sources show as one rise per two edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_r <= 1'b0;
			rises <= 16'h0000;
		end else begin
			last_r <= mon;
			if (mon && !last_r) begin
				rises <= rises + 16'h0001;
			end
		end
	end
endmodule

// file: bench/smm_top_test.sv
// self-checking testbench of the status monitor multiplexers
`timescale 1ns/1ps
module smm_top_test;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] rdata;
	smm_pkg::smm_status_t status = '0;
	logic [3:0] raw = 4'h0;
	logic mon0;
	logic mon1;
	logic irq;
	logic [15:0] rises;
	int bad_count = 0;
	int total_checks = 0;

	smm_top smm_top_i (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .STATUS(status), .PLL1_RAW(smm_pkg::smm_pll1_t'(raw)), .MON0(mon0), .MON1(mon1),
		.IRQ(irq));
	smm_observer smm_observer_i (.clk(mclk), .rst_n(rst_n), .mon(mon0), .rises(rises));

	// 20 MHz clock
	initial begin
		forever #25 mclk = ~mclk;
	end

	// compare and count
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle only
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// monitor level expected for a select code and a set of conditions
	function automatic logic expect_mon(input logic [5:0] c, input smm_pkg::smm_status_t s);
		case (c)
			6'h01: return s.pll1_lock & s.pll2_lock;
			6'h02: return s.pll1_lock;
			6'h03: return s.pll2_lock;
			6'h04: return s.both_missing;
			6'h05: return s.both_missing & s.pll2_lock;
			6'h06: return s.second_selected;
			6'h07: return s.first_ok;
			6'h08: return s.second_ok;
			6'h09: return s.test_ok;
			6'h0a: return s.xo_ok;
			6'h0b: return s.pll1_fb_ok;
			6'h0c: return s.pll2_ref_ok;
			6'h0e: return s.first_ok & s.second_ok;
			6'h0f: return s.first_ok & s.second_ok & s.xo_ok & s.pll1_fb_ok & s.pll2_ref_ok & s.pll2_fb_ok;
			default: return 1'b0;
		endcase
	endfunction

	// reset pulse of two cycles, then everything idle and selects back at ground
	task automatic t_reset();
		logic [7:0] d;
		@(posedge mclk);
		rst_n <= 1'b0;
		wait_clk(1);
		check("mon0 in reset", {7'h00, mon0}, 8'h00);
		@(posedge mclk);
		rst_n <= 1'b1;
		rd(10'h230, d);
		check("select zero reset", d, 8'h00);
		rd(10'h231, d);
		check("select one reset", d, 8'h00);
		rd(10'h239, d);
		check("mask reset", d, 8'h00);
		check("monitors and irq after reset", {5'h00, mon0, mon1, irq}, 8'h00);
	endtask

	// select registers keep six bits, reserved bits and unmapped places read zero
	task automatic t_regs();
		logic [7:0] d;
		wr(10'h230, 8'hd7);
		wr(10'h231, 8'hc5);
		rd(10'h230, d);
		check("select zero field", d, 8'h17);
		rd(10'h231, d);
		check("select one field", d, 8'h05);
		rd(10'h3ff, d);
		check("unmapped read", d, 8'h00);
		wait_clk(4);
		check("mon0 code 23", {7'h00, mon0}, 8'h00);
	endtask

	// static codes 0 to 15 and 20 to 23 on both monitors under many condition patterns
	task automatic t_decode();
		smm_pkg::smm_status_t s;
		logic [5:0] c;
		for (int p = 0; p < 13; p++) begin
			s = (p == 11) ? '1 : (p == 12) ? '0 : smm_pkg::smm_status_t'(~(11'h001 << p));
			@(posedge mclk);
			status <= s;
			for (int k = 0; k < 20; k++) begin
				c = (k < 16) ? 6'(k) : 6'(k + 4);
				wr(10'h230, {2'b00, c});
				wr(10'h231, {2'b00, c});
				wait_clk(4);
				check("mon0 decode", {7'h00, mon0}, {7'h00, expect_mon(c, s)});
				check("mon1 decode", {7'h00, mon1}, {7'h00, expect_mon(c, s)});
			end
		end
	endtask

	// half-rate sources: four raw edges give exactly two monitor rises, each on its own code
	task automatic t_half();
		logic [15:0] base;
		for (int k = 0; k < 4; k++) begin
			wr(10'h230, 8'(16 + k));
			wait_clk(4);
			base = rises;
			repeat (4) begin
				@(posedge mclk);
				raw[3 - k] <= 1'b1;
				repeat (4) @(posedge mclk);
				raw[3 - k] <= 1'b0;
				wait_clk(4);
			end
			wait_clk(4);
			check("half-rate rises", 8'(rises - base), 8'h02);
		end
	endtask

	// sticky monitor-rise event, masked then unmasked, cleared by writing one
	task automatic t_irq();
		logic [7:0] d;
		@(posedge mclk);
		status <= smm_pkg::smm_status_t'(11'h3ff); // every condition but the first lock
		wr(10'h230, 8'h02);
		wr(10'h231, 8'h00);
		wait_clk(5);
		wr(10'h238, 8'h0f);
		wait_clk(2);
		rd(10'h238, d);
		check("irq status cleared", d, 8'h00);
		@(posedge mclk);
		status.pll1_lock <= 1'b1;
		wait_clk(6);
		check("irq masked", {7'h00, irq}, 8'h00);
		check("mon0 lock", {7'h00, mon0}, 8'h01);
		rd(10'h238, d);
		check("irq status set", d, 8'h01);
		wr(10'h239, 8'h01);
		wait_clk(2);
		check("irq unmasked", {7'h00, irq}, 8'h01);
		wr(10'h238, 8'h01);
		wait_clk(2);
		check("irq after clear", {7'h00, irq}, 8'h00);
		rd(10'h238, d);
		check("irq status after clear", d, 8'h00);
		// dropping the second lock is a lock-lost event, live registers show the new picture
		@(posedge mclk);
		status.pll2_lock <= 1'b0;
		wait_clk(4);
		rd(10'h238, d);
		check("irq lock lost", d, 8'h04);
		rd(10'h23a, d);
		check("live clock status", d, 8'hfd);
		rd(10'h23b, d);
		check("live monitor status", d, 8'h0f);
	endtask

	// main sequence, ending with a mid-run reset
	initial begin
		t_reset();
		t_regs();
		t_decode();
		t_half();
		t_irq();
		t_reset();
		end_of_test();
	end

	// watchdog well beyond the expected run of about 2400 cycles
	initial begin
		#2000000;
		bad_count++;
		end_of_test();
	end
endmodule
